/* hw/rtc_alarm_pkg.sv */
// Constants, field layouts and carrier types of the alarm compare block.
// Assumes one 100 MHz clock and a plain register port from software.
//
// Contract
// - Compare only enabled alarm fields; alarm when every enabled field matches. The code raises no alarm while no field is enabled.
// - Power-on reset clears each alarm enable; BCD fields are never reset.
// - Hour alarm holds BCD 00-23; bit 6 reads zero.
// - Weekday alarm holds code 0-6, Sunday zero; bits 6 to 3 read zero.
// - Month alarm holds BCD 01-12; bits 6 and 5 read zero.
// - Power-on zeroes control; manual reset zeroes all but carry flag; standby keeps.
// - Carry flag sets on every 64 Hz or seconds counter increment.
// - Writing 0 clears carry flag; writing 1 sets it.
// - Carry interrupt requested while carry flag set and its enable is 1.
// - Alarm interrupt requested while alarm flag set and its enable is 1.
// - Alarm flag sets when running time equals the enabled alarm fields.
// - Writing 0 clears alarm flag; writing 1 leaves it unchanged.
// - Control bits 6, 5, 2, 1 read zero; software writes zero there.
// - Seconds alarm with enable joins the match; enable cleared on power-on.

package rtc_alarm_pkg;

  // =====================================================
  // Register map
  localparam int unsigned ADDR_W        = 3;
  localparam int unsigned NUM_ALARMS    = 6;
  localparam logic [2:0] OFS_SECOND_AL  = 3'h0;
  localparam logic [2:0] OFS_MINUTE_AL  = 3'h1;
  localparam logic [2:0] OFS_HOUR_AL    = 3'h2;
  localparam logic [2:0] OFS_WEEKDAY_AL = 3'h3;
  localparam logic [2:0] OFS_DATE_AL    = 3'h4;
  localparam logic [2:0] OFS_MONTH_AL   = 3'h5;
  localparam logic [2:0] OFS_CONTROL    = 3'h6;

  // =====================================================
  // Field positions
  localparam int unsigned ENABLE_BIT = 7;
  localparam int unsigned CF_BIT     = 7;
  localparam int unsigned CIE_BIT    = 4;
  localparam int unsigned AIE_BIT    = 3;
  localparam int unsigned AF_BIT     = 0;

  // =====================================================
  // Writable value bits below the enable of each alarm register
  localparam logic [6:0] SECOND_MASK  = 7'h7f;
  localparam logic [6:0] MINUTE_MASK  = 7'h7f;
  localparam logic [6:0] HOUR_MASK    = 7'h3f;
  localparam logic [6:0] WEEKDAY_MASK = 7'h07;
  localparam logic [6:0] DATE_MASK    = 7'h3f;
  localparam logic [6:0] MONTH_MASK   = 7'h1f;

  // =====================================================
  // Reset values
  localparam logic       ENABLE_RESET  = 1'b0;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] READ_IDLE     = 8'h00;

  // =====================================================
  // Carriers
  typedef struct packed {
    logic              wr;    // Write strobe
    logic              rd;    // Read strobe
    logic [ADDR_W-1:0] addr;  // Register offset
    logic [7:0]        wdata; // Write data
  } reg_req_t;

  typedef struct packed {
    logic [7:0] second;  // Seconds counter, BCD
    logic [7:0] minute;  // Minutes counter, BCD
    logic [7:0] hour;    // Hours counter, BCD
    logic [7:0] weekday; // Weekday counter, code 0-6
    logic [7:0] date;    // Date counter, BCD
    logic [7:0] month;   // Month counter, BCD
  } time_count_t;

endpackage

/* hw/rtc_alarm_compare.sv */
// Alarm compare registers, carry and alarm flags, interrupt requests.
// Assumes time counters and carry pulses come from logic on clk;
// manual reset and standby arrive from outside and are synchronised.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module rtc_alarm_compare (
  input  wire logic                       clk,              // 100 MHz clock
  input  wire logic                       reset,            // Power-on reset
  input  wire logic                       manual_reset,     // Manual reset level
  input  wire logic                       standby,          // Standby level
  input  wire rtc_alarm_pkg::reg_req_t    reg_req,          // Register request
  output logic [7:0]                      reg_rdata,        // Read data
  input  wire rtc_alarm_pkg::time_count_t time_count,       // Running time
  input  wire logic                       sixty_four_hz_inc, // 64 Hz count pulse
  input  wire logic                       seconds_inc,      // Seconds count pulse
  output logic                            carry_irq,        // Carry request
  output logic                            alarm_irq         // Alarm request
);

  // =====================================================
  // Field mask by alarm index, used by write and compare
  function automatic logic [6:0] field_mask(input int unsigned idx);
    logic [6:0] m;
    m = rtc_alarm_pkg::SECOND_MASK;
    case (idx)
      1: m = rtc_alarm_pkg::MINUTE_MASK;
      2: m = rtc_alarm_pkg::HOUR_MASK;
      3: m = rtc_alarm_pkg::WEEKDAY_MASK;
      4: m = rtc_alarm_pkg::DATE_MASK;
      5: m = rtc_alarm_pkg::MONTH_MASK;
      default: m = rtc_alarm_pkg::SECOND_MASK;
    endcase
    return m;
  endfunction

  // =====================================================
  // Declarations
  logic                                   manual_s1_reg;
  logic                                   manual_s2_reg;
  logic                                   standby_s1_reg;
  logic                                   standby_s2_reg;
  logic [rtc_alarm_pkg::NUM_ALARMS-1:0]   enable_reg;
  logic [6:0]                             field_reg [rtc_alarm_pkg::NUM_ALARMS];
  logic [6:0]                             count_val [rtc_alarm_pkg::NUM_ALARMS];
  logic [rtc_alarm_pkg::NUM_ALARMS-1:0]   wr_sel;
  logic [rtc_alarm_pkg::NUM_ALARMS-1:0]   field_hit;
  logic                                   write_ok;
  logic                                   ctrl_wr;
  logic                                   all_match;
  logic                                   match_reg;
  logic                                   match_rise;
  logic                                   carry_event;
  logic                                   cf_reg;
  logic                                   cf_next;
  logic                                   cie_reg;
  logic                                   cie_next;
  logic                                   aie_reg;
  logic                                   aie_next;
  logic                                   af_reg;
  logic                                   af_next;
  logic [7:0]                             control_view;
  logic [7:0]                             rdata_next;
  logic [7:0]                             rdata_reg;

  // =====================================================
  // Synchronisers for the outside levels; only stage two is read
  always_ff @(posedge clk) begin
    if (reset) begin
      manual_s1_reg  <= 1'b0;
      manual_s2_reg  <= 1'b0;
      standby_s1_reg <= 1'b0;
      standby_s2_reg <= 1'b0;
    end else begin
      manual_s1_reg  <= manual_reset;
      manual_s2_reg  <= manual_s1_reg;
      standby_s1_reg <= standby;
      standby_s2_reg <= standby_s1_reg;
    end
  end

  // =====================================================
  // Write qualification
  // Writes are dropped in standby so retained state cannot be disturbed
  assign write_ok = reg_req.wr && !standby_s2_reg && !manual_s2_reg;
  assign ctrl_wr  = write_ok && (reg_req.addr == rtc_alarm_pkg::OFS_CONTROL);

  // =====================================================
  // Counter values in alarm index order
  assign count_val[0] = time_count.second[6:0];
  assign count_val[1] = time_count.minute[6:0];
  assign count_val[2] = time_count.hour[6:0];
  assign count_val[3] = time_count.weekday[6:0];
  assign count_val[4] = time_count.date[6:0];
  assign count_val[5] = time_count.month[6:0];

  // =====================================================
  // Alarm registers: six identical slices differing only in mask
  for (genvar i = 0; i < rtc_alarm_pkg::NUM_ALARMS; i++) begin : g_alarm
    assign wr_sel[i] = write_ok && (reg_req.addr == 3'(i));

    // Disabled fields always hit, so they drop out of the match
    assign field_hit[i] = !enable_reg[i] ||
        ((count_val[i] & field_mask(i)) == field_reg[i]);

    // Enable clears only on power-on; manual reset and standby keep it
    always_ff @(posedge clk) begin
      if (reset) begin
        enable_reg[i] <= rtc_alarm_pkg::ENABLE_RESET;
      end else if (wr_sel[i]) begin
        enable_reg[i] <= reg_req.wdata[rtc_alarm_pkg::ENABLE_BIT];
      end
    end

    // Value field has no reset at all, it is retained storage
    always_ff @(posedge clk) begin
      if (wr_sel[i]) begin
        field_reg[i] <= reg_req.wdata[6:0] & field_mask(i);
      end
    end
  end

  // =====================================================
  // Match detection
  // The flag sets on the first cycle of a match, so a clear written
  // while the time still matches is not undone straight away
  assign all_match  = (&field_hit) && (|enable_reg);
  assign match_rise = all_match && !match_reg;

  always_ff @(posedge clk) begin
    if (reset) begin
      match_reg <= 1'b0;
    end else begin
      match_reg <= all_match;
    end
  end

  // =====================================================
  // Flag next values; hardware set wins over a software clear
  assign carry_event = sixty_four_hz_inc || seconds_inc;

  assign cf_next = carry_event ? 1'b1 :
                   ctrl_wr ? reg_req.wdata[rtc_alarm_pkg::CF_BIT] :
                   cf_reg;

  assign af_next = match_rise ? 1'b1 :
                   (ctrl_wr && !reg_req.wdata[rtc_alarm_pkg::AF_BIT]) ? 1'b0 :
                   af_reg;

  assign cie_next = ctrl_wr ? reg_req.wdata[rtc_alarm_pkg::CIE_BIT] : cie_reg;
  assign aie_next = ctrl_wr ? reg_req.wdata[rtc_alarm_pkg::AIE_BIT] : aie_reg;

  // =====================================================
  // Control register state
  // Manual reset leaves the carry flag running: its value is not defined
  // for software, which must set it to a known state before use
  always_ff @(posedge clk) begin
    if (reset) begin
      cf_reg  <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::CF_BIT];
      cie_reg <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::CIE_BIT];
      aie_reg <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::AIE_BIT];
      af_reg  <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::AF_BIT];
    end else if (manual_s2_reg) begin
      cf_reg  <= cf_next;
      cie_reg <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::CIE_BIT];
      aie_reg <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::AIE_BIT];
      af_reg  <= rtc_alarm_pkg::CONTROL_RESET[rtc_alarm_pkg::AF_BIT];
    end else begin
      cf_reg  <= cf_next;
      cie_reg <= cie_next;
      aie_reg <= aie_next;
      af_reg  <= af_next;
    end
  end

  // =====================================================
  // Control register view; reserved bits are tied low
  always_comb begin
    control_view = 8'h00;
    control_view[rtc_alarm_pkg::CF_BIT]  = cf_reg;
    control_view[rtc_alarm_pkg::CIE_BIT] = cie_reg;
    control_view[rtc_alarm_pkg::AIE_BIT] = aie_reg;
    control_view[rtc_alarm_pkg::AF_BIT]  = af_reg;
  end

  // =====================================================
  // Read mux; stored fields are already masked, so unused bits read 0
  always_comb begin
    rdata_next = rtc_alarm_pkg::READ_IDLE;
    if (reg_req.addr == rtc_alarm_pkg::OFS_CONTROL) begin
      rdata_next = control_view;
    end else if (reg_req.addr < rtc_alarm_pkg::OFS_CONTROL) begin
      rdata_next = {enable_reg[reg_req.addr], field_reg[reg_req.addr]};
    end
  end

  // Read data stands for one cycle only, zero otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_reg <= rtc_alarm_pkg::READ_IDLE;
    end else begin
      rdata_reg <= reg_req.rd ? rdata_next : rtc_alarm_pkg::READ_IDLE;
    end
  end

  assign reg_rdata = rdata_reg;

  // =====================================================
  // Interrupt requests follow the flags, held until software or a reset clears them
  assign carry_irq = cf_reg && cie_reg;
  assign alarm_irq = af_reg && aie_reg;

endmodule // rtc_alarm_compare

`default_nettype wire

/* testbench/rtc_alarm_compare_properties.sv */
// Concurrent checks on the ports of the alarm compare block.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none

module rtc_alarm_compare_properties (
  input wire logic                       clk,               // Clock
  input wire logic                       reset,             // Power-on reset
  input wire logic                       manual_reset,      // Manual reset
  input wire logic                       standby,           // Standby
  input wire rtc_alarm_pkg::reg_req_t    reg_req,           // Register request
  input wire logic [7:0]                 reg_rdata,         // Read data
  input wire rtc_alarm_pkg::time_count_t time_count,        // Running time
  input wire logic                       sixty_four_hz_inc, // 64 Hz pulse
  input wire logic                       seconds_inc,       // Seconds pulse
  input wire logic                       carry_irq,         // Carry request
  input wire logic                       alarm_irq          // Alarm request
);
  // =====================================================
  // Read-back shape, then flag causes
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire rd_ctl = reg_req.rd && reg_req.addr == rtc_alarm_pkg::OFS_CONTROL;
  wire wr_ctl = reg_req.wr && reg_req.addr == rtc_alarm_pkg::OFS_CONTROL;

  a_unmapped_read_zero: assert property (reg_req.rd && reg_req.addr == 3'h7 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ctrl_reserved_zero: assert property (rd_ctl |=> reg_rdata[6:5] == 2'b00 && reg_rdata[2:1] == 2'b00)
    else $error("control reserved bits not zero");
  a_hour_bit_zero: assert property (reg_req.rd && reg_req.addr == 3'h2 |=> !reg_rdata[6])
    else $error("hour alarm bit 6 not zero");
  a_weekday_high_zero: assert property (reg_req.rd && reg_req.addr == 3'h3 |=> reg_rdata[6:3] == 4'h0)
    else $error("weekday alarm upper bits not zero");
  a_date_bit_zero: assert property (reg_req.rd && reg_req.addr == 3'h4 |=> !reg_rdata[6])
    else $error("date alarm bit 6 not zero");
  a_month_high_zero: assert property (reg_req.rd && reg_req.addr == 3'h5 |=> reg_rdata[6:5] == 2'b00)
    else $error("month alarm upper bits not zero");
  // A request may only drop because software or a reset took it away
  a_carry_irq_holds: assert property ($fell(carry_irq) |-> $past(wr_ctl) || $past(manual_reset) || $past(manual_reset, 3))
    else $error("carry request dropped without cause");
  a_alarm_irq_holds: assert property ($fell(alarm_irq) |-> $past(wr_ctl) || $past(manual_reset) || $past(manual_reset, 3))
    else $error("alarm request dropped without cause");
  a_carry_irq_cause: assert property ($rose(carry_irq) |-> $past(seconds_inc || sixty_four_hz_inc || wr_ctl))
    else $error("carry request rose without cause");

  c_carry: cover property ($rose(carry_irq));
  c_alarm: cover property ($rose(alarm_irq));
  c_ctrl_read: cover property (rd_ctl ##1 reg_rdata[0]);
endmodule // rtc_alarm_compare_properties

bind rtc_alarm_compare rtc_alarm_compare_properties u_props (.clk(clk), .reset(reset),
  .manual_reset(manual_reset), .standby(standby), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .time_count(time_count), .sixty_four_hz_inc(sixty_four_hz_inc), .seconds_inc(seconds_inc),
  .carry_irq(carry_irq), .alarm_irq(alarm_irq));
`default_nettype wire

/* testbench/rtc_alarm_compare_tb_top.sv */
// Self-checking bench of the alarm compare block.
// Assumes the register map and masks of the package.
`timescale 1ns/10ps
`default_nettype none

module rtc_alarm_compare_tb_top;
  logic                       clk, reset, manual_reset, standby, sf_inc, s_inc;
  rtc_alarm_pkg::reg_req_t    reg_req;
  rtc_alarm_pkg::time_count_t tc;
  logic [7:0]                 reg_rdata, v;
  logic                       carry_irq, alarm_irq;
  int                         mismatches, check_count, cycles, i;
  logic [6:0] masks [6] = '{7'h7f, 7'h7f, 7'h3f, 7'h07, 7'h3f, 7'h1f};

  rtc_alarm_compare uut (.clk(clk), .reset(reset), .manual_reset(manual_reset),
    .standby(standby), .reg_req(reg_req), .reg_rdata(reg_rdata), .time_count(tc),
    .sixty_four_hz_inc(sf_inc), .seconds_inc(s_inc), .carry_irq(carry_irq),
    .alarm_irq(alarm_irq));

  // =====================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  // =====================================================
  // Bus tasks; strobes drop at the same edge that takes them
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge clk) reg_req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge clk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge clk) reg_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic hour(input logic [7:0] h);
    @(posedge clk) tc.hour <= h;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic pulse(input logic slow);
    @(posedge clk) {sf_inc, s_inc} <= {slow, ~slow};
    @(posedge clk) {sf_inc, s_inc} <= 2'b00;
    #1;
  endtask
  task automatic give_verdict();
    if (mismatches == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // =====================================================
  // Main sequence
  initial begin
    {reset, manual_reset, standby, sf_inc, s_inc} = 5'b10000;
    reg_req = '0;
    tc = '0;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    rd(3'h6); check(v, 8'h00);
    for (i = 0; i < 6; i++) begin
      rd(3'(i)); check(v & 8'h80, 8'h00);
      wr(3'(i), 8'hff); rd(3'(i)); check(v, {1'b1, masks[i]});
      wr(3'(i), 8'h00);
    end
    rd(3'h7); check(v, 8'h00);
    // No enable set: time equals every field yet nothing fires
    wr(3'h6, 8'h08); hour(8'h00); check({7'h0, alarm_irq}, 8'h00);
    // Only minute and hour take part; the disabled second field differs
    wr(3'h0, 8'h05); wr(3'h1, 8'hb0); wr(3'h2, 8'h92);
    @(posedge clk) tc.minute <= 8'h30;
    hour(8'h11); check({7'h0, alarm_irq}, 8'h00);
    hour(8'h12); check({7'h0, alarm_irq}, 8'h01);
    // Control is always written whole, never read, changed and written back
    wr(3'h6, 8'h09); rd(3'h6); check(v, 8'h09);
    wr(3'h6, 8'h08); rd(3'h6); check(v, 8'h08);
    hour(8'h13); hour(8'h12); check({7'h0, alarm_irq}, 8'h01);
    wr(3'h6, 8'h01); hour(8'h13); hour(8'h12);
    check({7'h0, alarm_irq}, 8'h00);
    rd(3'h6); check(v, 8'h01);
    // Carry flag from both count pulses, with and without its enable
    wr(3'h6, 8'h10); check({7'h0, carry_irq}, 8'h00);
    pulse(1'b0); check({7'h0, carry_irq}, 8'h01);
    wr(3'h6, 8'h00); pulse(1'b1); check({7'h0, carry_irq}, 8'h00);
    rd(3'h6); check(v, 8'h80);
    wr(3'h6, 8'h00); rd(3'h6); check(v, 8'h00);
    wr(3'h6, 8'h80); rd(3'h6); check(v, 8'h80);
    wr(3'h6, 8'h66); rd(3'h6); check(v, 8'h00);
    // Manual reset keeps the minute alarm field; standby drops writes
    wr(3'h6, 8'h98);
    @(posedge clk) manual_reset <= 1'b1;
    repeat (4) @(posedge clk);
    manual_reset <= 1'b0;
    repeat (3) @(posedge clk);
    rd(3'h6); check(v & 8'h7f, 8'h00);
    wr(3'h6, 8'h00); rd(3'h6); check(v, 8'h00);
    rd(3'h1); check(v, 8'hb0);
    @(posedge clk) standby <= 1'b1;
    repeat (3) @(posedge clk);
    wr(3'h1, 8'h00);
    standby <= 1'b0;
    repeat (3) @(posedge clk);
    rd(3'h1); check(v, 8'hb0);
    give_verdict();
  end
endmodule // rtc_alarm_compare_tb_top
`default_nettype wire
